// ### core/scpt_prescaler.sv
/*
  scpt_prescaler: system clock prescaler with timed unlock and rc
  oscillator trim register, reached over axi4-lite.
  assumes SYS_CLK_I is the undivided source clock and the fuse and
  source-select inputs are static after reset.
*/
// Operation
// (R1) divide source clock for all derived clocks
// (R2) switch divided clock without glitches
// (R3) no intermediate frequency above old/new
// (R4) ripple-style counter on undivided clock
// (R5) new rate after two active edges
// (R6) unlock set only with other bits zero
// (R7) software writes select within four cycles
// (R8) unlock clears after four cycles or select write
// (R9) rewriting unlock neither extends nor clears
// (R10) software keeps interrupts off during sequence
// (R11) select 0..8 divides by two to select
// (R12) rc source doubles each division factor
// (R13) 0xF divides by one, rc only; code divides by one for 0xF on either source
// (R14) no programming with rc and 0xF
// (R15) reset select from divide-by-eight fuse
// (R16) any select accepted through unlock
// (R17) software picks safe division factor
// (R18) trim loaded with factory value at reset
// (R19) trim bit7 picks low or high range
// (R20) trim low bits tune monotonically
// (R21) memory write timing follows trimmed rc
// (R22) reserved prescale bits read zero
`timescale 1ns/1ps
module scpt_prescaler
  import scpt_pkg::*;
#(
  parameter int CNT_W = 10,
  parameter logic [7:0] FACTORY_TRIM = 8'h5A // arbitrary default
) (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  // straps
  input wire logic RESET_DIVIDE_BY_EIGHT_FUSE_I,
  input wire logic RC_SOURCE_SELECTED_I,
  // axi4-lite write
  input wire logic [11:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // axi4-lite read
  input wire logic [11:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // derived clocks and trim
  output scpt_pkg::scpt_clk_out_t CLK_OUT_O,
  output logic [7:0] RC_TRIM_O,
  output logic MEM_PROGRAM_ALLOWED_O
);
  import scpt_pkg::*;

  // the slowest rate needs an eight-bit half count; two spare bits kept
  if (CNT_W < 10) begin : g_cnt_w_check
    $error("CNT_W must be at least 10");
  end

  // write channel capture, address and data in either order
  logic aw_held_r, w_held_r, bvalid_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r;
  logic arvalid_ok, rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  assign S_AXI_AWREADY_O = !aw_held_r && !bvalid_r;
  assign S_AXI_WREADY_O = !w_held_r && !bvalid_r;
  assign S_AXI_BVALID_O = bvalid_r;
  assign S_AXI_BRESP_O = bresp_r;
  assign S_AXI_ARREADY_O = !rvalid_r;
  assign S_AXI_RVALID_O = rvalid_r;
  assign S_AXI_RDATA_O = rdata_r;
  assign S_AXI_RRESP_O = rresp_r;

  wire aw_take = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
  wire w_take = S_AXI_WVALID_I && S_AXI_WREADY_O;
  wire aw_have = aw_held_r || aw_take;
  wire w_have = w_held_r || w_take;
  wire wr_fire = aw_have && w_have && !bvalid_r;
  wire [11:0] wr_addr = aw_held_r ? awaddr_r : S_AXI_AWADDR_I;
  wire [31:0] wr_data = w_held_r ? wdata_r : S_AXI_WDATA_I;
  wire wr_lane0 = w_held_r ? wstrb_r[0] : S_AXI_WSTRB_I[0];

  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == SCPT_ADDR_DIVIDE_CONTROL) || (a == SCPT_ADDR_RC_TRIM)
      || (a == SCPT_ADDR_FUSE_STATUS);
  endfunction : addr_mapped

  wire wr_ctrl = wr_fire && wr_lane0 && (wr_addr == SCPT_ADDR_DIVIDE_CONTROL);
  wire wr_trim = wr_fire && wr_lane0 && (wr_addr == SCPT_ADDR_RC_TRIM);

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= SCPT_RESP_OKAY;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (aw_take) begin
        awaddr_r <= S_AXI_AWADDR_I;
      end
      if (w_take) begin
        wdata_r <= S_AXI_WDATA_I;
        wstrb_r <= S_AXI_WSTRB_I;
      end
      aw_held_r <= aw_have && !wr_fire;
      w_held_r <= w_have && !wr_fire;
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= addr_mapped(wr_addr) ? SCPT_RESP_OKAY : SCPT_RESP_SLVERR;
      end else if (S_AXI_BREADY_I) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // unlock and select
  logic unlock_r;
  logic [2:0] unlock_cnt_r;
  logic [3:0] sel_r;
  logic [7:0] trim_r;
  logic fuse_cap_r;
  // unlock only with all other bits zero; a rewrite while armed is ignored
  wire unlock_req = wr_ctrl && wr_data[SCPT_UNLOCK_BIT] && (wr_data[6:0] == 7'h00); // (R6)
  wire sel_write = wr_ctrl && !wr_data[SCPT_UNLOCK_BIT];
  wire sel_commit = sel_write && unlock_r; // (R16)
  wire unlock_expire = unlock_r && (unlock_cnt_r == SCPT_UNLOCK_CYCLES - 3'h1);

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      unlock_r <= 1'b0;
      unlock_cnt_r <= 3'h0;
      trim_r <= SCPT_TRIM_RESET;
      sel_r <= SCPT_SEL_RESET_PLAIN;
      fuse_cap_r <= 1'b0;
    end else begin
      fuse_cap_r <= RESET_DIVIDE_BY_EIGHT_FUSE_I;
      if (unlock_r) begin
        unlock_cnt_r <= unlock_cnt_r + 3'h1; // (R9)
        if (sel_write || unlock_expire) begin
          unlock_r <= 1'b0; // (R8)
        end
      end else if (unlock_req) begin
        unlock_r <= 1'b1;
        unlock_cnt_r <= 3'h0;
      end
      if (sel_commit) begin
        sel_r <= wr_data[3:0];
      end
      if (wr_trim) begin
        trim_r <= wr_data[7:0]; // (R18)
      end
    end
  end

  // straps caught after release: first clean cycle loads reset values
  logic loaded_r;
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      loaded_r <= 1'b0;
    end else begin
      loaded_r <= 1'b1;
    end
  end
  wire [3:0] reset_sel = fuse_cap_r ? SCPT_SEL_RESET_DIV8 : SCPT_SEL_RESET_PLAIN; // (R15)
  wire [7:0] trim_init = FACTORY_TRIM; // (R18)
  logic [3:0] sel_eff;
  logic [7:0] trim_eff;
  logic sel_over_r, trim_over_r;
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      sel_over_r <= 1'b0;
      trim_over_r <= 1'b0;
    end else begin
      sel_over_r <= sel_over_r || (loaded_r && sel_commit);
      trim_over_r <= trim_over_r || (loaded_r && wr_trim);
    end
  end
  assign sel_eff = sel_over_r ? sel_r : reset_sel;
  assign trim_eff = trim_over_r ? trim_r : trim_init;
  // trim drives the rc: bit7 range, bits 6..0 fine, so memory timing follows it
  assign RC_TRIM_O = trim_eff; // (R19) (R20) (R21)

  // divide exponent: 2^sel, rc source one more; 0xF gives 1 on either source
  function automatic logic [3:0] div_exp(input logic [3:0] s, input logic rc);
    if (s == SCPT_SEL_RC_DIV1) begin
      div_exp = 4'h0; // (R13)
    end else if (s > SCPT_SEL_MAX_POW) begin
      div_exp = rc ? 4'h1 : 4'h0; // reserved codes: keep safe minimum
    end else begin
      div_exp = s + (rc ? 4'h1 : 4'h0); // (R11) (R12)
    end
  endfunction : div_exp

  // divider: counter on the undivided clock; the rate changes only when
  // the running count wraps, so no short pulse and no faster interim rate
  logic [CNT_W-1:0] cnt_r;
  logic [3:0] exp_r, exp_pend_r;
  logic clk_div_r;
  wire [3:0] exp_req = div_exp(sel_eff, RC_SOURCE_SELECTED_I);
  wire [CNT_W-1:0] half_mask = (exp_r == 4'h0) ? '0
    : CNT_W'((1 << (exp_r - 4'h1)) - 1);
  wire at_half = (cnt_r == half_mask); // (R4)
  wire period_end = (exp_r == 4'h0) || (clk_div_r == 1'b0 && at_half);

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      cnt_r <= '0;
      exp_r <= 4'h0;
      exp_pend_r <= 4'h0;
      clk_div_r <= 1'b1;
    end else begin
      exp_pend_r <= exp_req;
      if (exp_r == 4'h0) begin
        clk_div_r <= 1'b1;
        exp_r <= exp_pend_r; // (R2)
        cnt_r <= '0;
      end else if (at_half) begin
        cnt_r <= '0;
        clk_div_r <= !clk_div_r;
        if (period_end) begin
          exp_r <= exp_pend_r; // (R3) (R5)
        end
      end else begin
        cnt_r <= cnt_r + CNT_W'(1);
      end
    end
  end

  // undivided: pass the source clock; divided: the registered toggle
  wire clk_sel = (exp_r == 4'h0) ? SYS_CLK_I : clk_div_r; // (R1)
  assign CLK_OUT_O.core_clk = clk_sel;
  assign CLK_OUT_O.io_clk = clk_sel;
  assign CLK_OUT_O.conv_clk = clk_sel;
  assign CLK_OUT_O.mem_clk = clk_sel;
  assign MEM_PROGRAM_ALLOWED_O = !(RC_SOURCE_SELECTED_I && sel_eff == SCPT_SEL_RC_DIV1);

  // reads
  assign arvalid_ok = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  wire [31:0] rd_word =
    (S_AXI_ARADDR_I == SCPT_ADDR_DIVIDE_CONTROL) ? {24'h00_0000, unlock_r, 3'b000, sel_eff} // (R22)
    : (S_AXI_ARADDR_I == SCPT_ADDR_RC_TRIM) ? {24'h00_0000, trim_eff}
    : (S_AXI_ARADDR_I == SCPT_ADDR_FUSE_STATUS)
      ? {28'h000_0000, exp_r == 4'h0, MEM_PROGRAM_ALLOWED_O, RC_SOURCE_SELECTED_I, fuse_cap_r}
    : 32'h0000_0000;
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= SCPT_RESP_OKAY;
    end else if (arvalid_ok) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= addr_mapped(S_AXI_ARADDR_I) ? SCPT_RESP_OKAY : SCPT_RESP_SLVERR;
    end else if (S_AXI_RREADY_I) begin
      rvalid_r <= 1'b0;
    end
  end

  // checks
  a_unlock_window: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // (R8)
    $rose(unlock_r) |-> ##[1:4] !unlock_r)
    else $error("unlock stayed beyond four cycles");
  a_unlock_gate: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // (R6)
    (wr_ctrl && wr_data[6:0] != 7'h00 && !unlock_r) |=> !unlock_r)
    else $error("unlock set with other bits nonzero");
  a_no_extend: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // (R9)
    (unlock_r && unlock_req) |=> (unlock_cnt_r == $past(unlock_cnt_r) + 3'h1))
    else $error("unlock window restarted");
  a_locked_sel: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // (R16)
    (sel_write && !unlock_r) |=> (sel_r == $past(sel_r)))
    else $error("select changed without unlock");
  a_sel_commit: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // (R16)
    sel_commit |=> (sel_r == $past(wr_data[3:0])) && !unlock_r)
    else $error("select not taken");
  a_reserved_zero: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // (R22)
    (rvalid_r && $past(arvalid_ok && S_AXI_ARADDR_I == SCPT_ADDR_DIVIDE_CONTROL))
      |-> rdata_r[6:4] == 3'b000)
    else $error("reserved bits not zero");
  a_reset_sel: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // (R15)
    (loaded_r && !sel_over_r) |-> sel_eff == ($past(RESET_DIVIDE_BY_EIGHT_FUSE_I)
      ? SCPT_SEL_RESET_DIV8 : SCPT_SEL_RESET_PLAIN))
    else $error("reset select wrong");
  a_rate_hold: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // (R2)
    (exp_r != 4'h0 && !at_half) |=> $stable(clk_div_r))
    else $error("divided clock changed mid phase");
  a_exp_map: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // (R12)
    (RC_SOURCE_SELECTED_I && sel_eff <= 4'h8) |-> exp_req == sel_eff + 4'h1)
    else $error("rc exponent wrong");
  a_unlock_sel_clear: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // (R8)
    (unlock_r && sel_write) |=> !unlock_r)
    else $error("unlock kept after select write");
  a_switch_point: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // (R3)
    (exp_r != 4'h0 && !period_end) |=> exp_r == $past(exp_r))
    else $error("rate changed inside a period");
  a_exp_range: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // (R11)
    exp_req <= SCPT_SEL_MAX_POW + 4'h1)
    else $error("divide exponent out of range");
  a_div_one: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // (R13)
    (sel_eff == SCPT_SEL_RC_DIV1) |=> exp_pend_r == 4'h0)
    else $error("select 0xF not undivided");
  a_trim_factory: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // (R18)
    !trim_over_r |-> RC_TRIM_O == FACTORY_TRIM)
    else $error("factory trim not applied");

  // a committed select must reach the divider within 600 cycles, just over one slowest period of 512;
  // the pending stage follows the latest select, so a quick rewrite still lands
  sequence s_sel_taken;
    sel_commit ##1 (exp_req != exp_r);
  endsequence
  sequence s_rate_adopted;
    ##[1:600] (exp_r == exp_req);
  endsequence
  a_rate_adopt: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // (R5)
    s_sel_taken |-> s_rate_adopted)
    else $error("new rate not adopted");
endmodule : scpt_prescaler

// ### include/scpt_pkg.sv
/*
  scpt_pkg: constants and carrier types for the system clock prescaler
  and rc trim block. assumes an axi4-lite slave with 32-bit data.
*/
package scpt_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] SCPT_IDX_DIVIDE_CONTROL = 8'h61;
  localparam logic [7:0] SCPT_IDX_RC_TRIM = 8'h66;
  localparam logic [7:0] SCPT_IDX_FUSE_STATUS = 8'h68;
  localparam logic [11:0] SCPT_ADDR_DIVIDE_CONTROL = {2'b00, SCPT_IDX_DIVIDE_CONTROL, 2'b00};
  localparam logic [11:0] SCPT_ADDR_RC_TRIM = {2'b00, SCPT_IDX_RC_TRIM, 2'b00};
  localparam logic [11:0] SCPT_ADDR_FUSE_STATUS = {2'b00, SCPT_IDX_FUSE_STATUS, 2'b00};
  // field positions
  localparam int SCPT_UNLOCK_BIT = 7;
  localparam int SCPT_TRIM_RANGE_BIT = 7;
  // reset values
  localparam logic [3:0] SCPT_SEL_RESET_PLAIN = 4'h0;
  localparam logic [3:0] SCPT_SEL_RESET_DIV8 = 4'h3;
  localparam logic [7:0] SCPT_TRIM_RESET = 8'h00;
  // encodings
  localparam logic [3:0] SCPT_SEL_MAX_POW = 4'h8;
  localparam logic [3:0] SCPT_SEL_RC_DIV1 = 4'hF;
  // timing: unlock window in undivided source clock cycles
  localparam logic [2:0] SCPT_UNLOCK_CYCLES = 3'h4;
  localparam logic [1:0] SCPT_RESP_OKAY = 2'b00;
  localparam logic [1:0] SCPT_RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    SCPT_SW_IDLE = 2'b00,
    SCPT_SW_WAIT = 2'b01
  } scpt_sw_state_t;

  typedef struct packed {
    logic core_clk;
    logic io_clk;
    logic conv_clk;
    logic mem_clk;
  } scpt_clk_out_t;
endpackage : scpt_pkg

// ### verification/scpt_tb.sv
/*
  tb: self-checking bench for scpt_prescaler, driving axi4-lite from the bench.
  assumes the scpt_pkg constants and a 50 ns source clock; straps change only in reset.
*/
`timescale 1ns/1ps
module tb;
  import scpt_pkg::*;
  localparam logic [7:0] FT = 8'hA5; // arbitrary factory trim
  logic clk, rst, fuse, rcsel;
  logic [11:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, allowed;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, sel;
  logic [1:0] bresp, rresp, rs;
  logic [7:0] trim, tv;
  scpt_clk_out_t clko;
  int num_errors = 0;
  int checks = 0;
  int p, prev;

  scpt_prescaler #(.CNT_W(10), .FACTORY_TRIM(FT)) DUT (
    .SYS_CLK_I(clk), .RESET_I(rst), .RESET_DIVIDE_BY_EIGHT_FUSE_I(fuse),
    .RC_SOURCE_SELECTED_I(rcsel), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb),
    .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
    .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .CLK_OUT_O(clko), .RC_TRIM_O(trim), .MEM_PROGRAM_ALLOWED_O(allowed));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task print_verdict;
    if (num_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  task check(string what, logic [31:0] exp, logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task do_reset(logic f, logic r);
    @(posedge clk);
    rst <= 1'b1;
    fuse <= f;
    rcsel <= r;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : do_reset

  task axi_write(logic [11:0] a, logic [7:0] d);
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h00_0000, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    rs = bresp;
  endtask : axi_write

  task axi_read(logic [11:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
  endtask : axi_read

  task set_div(logic [7:0] v);
    // no interrupts in the bench: the two writes go back to back
    axi_write(SCPT_ADDR_DIVIDE_CONTROL, 8'h80);
    axi_write(SCPT_ADDR_DIVIDE_CONTROL, v);
  endtask : set_div

  // early intervals may still be the old rate, but none may be shorter than both
  task chk_rate(int exp_p, int min_p);
    realtime t[4];
    for (int k = 0; k < 4; k++) begin
      @(posedge clko.core_clk);
      t[k] = $realtime;
    end
    for (int k = 1; k < 3; k++) begin
      check("switch interval", 1, (t[k] - t[k-1]) >= min_p * 50.0);
    end
    check("divided period", exp_p, int'((t[3] - t[2]) / 50.0));
    @(negedge clk);
    check("clock copies", {3{clko.core_clk}}, {clko.io_clk, clko.conv_clk, clko.mem_clk});
  endtask : chk_rate

  initial begin
    repeat (80000) @(posedge clk);
    num_errors++;
    print_verdict;
  end

  initial begin
    rst = 1'b1;
    fuse = 1'b0;
    rcsel = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    do_reset(1'b0, 1'b0);
    axi_read(SCPT_ADDR_DIVIDE_CONTROL);
    check("select reset", 32'h0000_0000, rd);
    axi_read(SCPT_ADDR_RC_TRIM);
    check("trim reset", {24'h00_0000, FT}, rd);
    check("trim out reset", {24'h00_0000, FT}, trim);
    axi_write(SCPT_ADDR_DIVIDE_CONTROL, 8'h80);
    check("unlock resp", SCPT_RESP_OKAY, rs);
    axi_read(SCPT_ADDR_DIVIDE_CONTROL);
    check("unlock set", 32'h0000_0080, rd);
    repeat (6) @(posedge clk);
    axi_read(SCPT_ADDR_DIVIDE_CONTROL);
    check("unlock timeout", 32'h0000_0000, rd);
    axi_write(SCPT_ADDR_DIVIDE_CONTROL, 8'h05);
    axi_read(SCPT_ADDR_DIVIDE_CONTROL);
    check("locked write", 32'h0000_0000, rd);
    axi_write(SCPT_ADDR_DIVIDE_CONTROL, 8'h81);
    axi_write(SCPT_ADDR_DIVIDE_CONTROL, 8'h05);
    axi_read(SCPT_ADDR_DIVIDE_CONTROL);
    check("impure unlock", 32'h0000_0000, rd);
    // rewrite lands inside the window; a restarted window would let the select in
    axi_write(SCPT_ADDR_DIVIDE_CONTROL, 8'h80);
    axi_write(SCPT_ADDR_DIVIDE_CONTROL, 8'h80);
    axi_write(SCPT_ADDR_DIVIDE_CONTROL, 8'h05);
    axi_read(SCPT_ADDR_DIVIDE_CONTROL);
    check("window not extended", 32'h0000_0000, rd);
    set_div(8'h72);
    axi_read(SCPT_ADDR_DIVIDE_CONTROL);
    check("reserved bits", 32'h0000_0002, rd);
    for (int k = 0; k < 3; k++) begin
      tv = (k == 0) ? 8'h7F : (k == 1) ? 8'h80 : 8'h00;
      axi_write(SCPT_ADDR_RC_TRIM, tv);
      check("trim resp", SCPT_RESP_OKAY, rs);
      axi_read(SCPT_ADDR_RC_TRIM);
      check("trim readback", {24'h00_0000, tv}, rd);
      check("trim out", tv, trim);
    end
    axi_read(12'h000);
    check("unmapped resp", SCPT_RESP_SLVERR, rs);
    check("unmapped data", 32'h0000_0000, rd);
    for (int rc = 0; rc < 2; rc++) begin
      do_reset(1'b0, rc[0]);
      prev = 1 << rc;
      for (int i = 0; i < 10 + rc; i++) begin
        sel = (i == 10) ? 4'hF : 4'(i);
        p = (sel == 4'hF) ? 1 : (sel > 4'h8) ? (1 << rc) : (1 << (sel + rc));
        set_div({4'h0, sel});
        axi_read(SCPT_ADDR_DIVIDE_CONTROL);
        check("select", {28'h000_0000, sel}, rd);
        check("program allowed", (rc == 1 && sel == 4'hF) ? 1'b0 : 1'b1, allowed);
        chk_rate(p, (p < prev) ? p : prev);
        prev = p;
      end
    end
    do_reset(1'b1, 1'b0);
    axi_read(SCPT_ADDR_DIVIDE_CONTROL);
    check("fuse reset", 32'h0000_0003, rd);
    axi_read(SCPT_ADDR_FUSE_STATUS);
    check("status", 32'h0000_0005, rd);
    chk_rate(8, 8);
    set_div(8'h00);
    axi_read(SCPT_ADDR_DIVIDE_CONTROL);
    check("fuse override", 32'h0000_0000, rd);
    print_verdict;
  end
endmodule : tb
